// *** logic/csf_status_flags.sv ***
// Processor status word with sticky clip flags, priority field, AHB-Lite access and interrupt.
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module csf_status_flags (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic      [31:0]           hrdata_o,
  output logic                       hreadyout_o,
  output logic      [1:0]            hresp_o,
  input  wire csf_pkg::csf_acc_evt_t acc_evt_i,
  input  wire csf_pkg::csf_alu_req_t alu_req_i,
  output logic      [15:0]           cpu_status_word_o,
  output logic                       nesting_disable_o,
  output logic                       irq_o
);
  import csf_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Matches a byte address against a register offset.
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
    addr_hit = (addr == off);
  endfunction

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        next_wr_pend;
  logic [7:0]  acc_addr;
  logic        acc_take;

  // A transfer is taken when selected, NONSEQ and the bus is ready.
  assign acc_take     = hsel_i && hready_i && (htrans_i == CSF_HTRANS_NSEQ);
  assign acc_addr     = haddr_i[7:0];
  assign next_wr_pend = acc_take && hwrite_i;

  // Address phase of a write is held for its data phase.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= acc_addr;
    end
  end

  // Data phase write strobes per writable register; the interrupt status register has none.
  logic sw_status_wr;
  logic sw_ctrl_wr;
  logic sw_clr_wr;
  logic sw_en_wr;

  assign sw_status_wr = wr_pend && addr_hit(wr_addr, CSF_OFF_STATUS);
  assign sw_ctrl_wr   = wr_pend && addr_hit(wr_addr, CSF_OFF_CONTROL);
  assign sw_clr_wr    = wr_pend && addr_hit(wr_addr, CSF_OFF_IRQ_CLR);
  assign sw_en_wr     = wr_pend && addr_hit(wr_addr, CSF_OFF_IRQ_EN);

  // ----------------------------------------------------------------
  // Status word next value
  // ----------------------------------------------------------------
  logic [15:0] status;
  logic [15:0] next_status;
  logic        nest_dis;
  logic        next_nest_dis;
  logic        hc_w;
  logic        ovf_a_w;
  logic        ovf_b_w;
  logic        clip_a_w;
  logic        clip_b_w;
  logic        half_w;
  logic [2:0]  prio_w;
  logic [3:0]  gen_w;
  logic        clip_keep;
  logic [15:0] wd;

  assign wd = hwdata_i[15:0];

  csf_half_carry u_half_carry (
    .byte_mode_i  (alu_req_i.byte_mode),
    .sub_i        (alu_req_i.sub),
    .op_a_i       (alu_req_i.op_a),
    .op_b_i       (alu_req_i.op_b),
    .half_carry_o (hc_w)
  );

  // Datapath updates take priority over a software write in the same cycle.
  assign ovf_a_w = acc_evt_i.valid ? acc_evt_i.a_ovf : (sw_status_wr ? wd[CSF_B_OVF_A] : status[CSF_B_OVF_A]);
  assign ovf_b_w = acc_evt_i.valid ? acc_evt_i.b_ovf : (sw_status_wr ? wd[CSF_B_OVF_B] : status[CSF_B_OVF_B]);

  // A zero in the combined clip bit clears both sticky flags; a new saturation still wins.
  assign clip_keep = wd[CSF_B_CLIP_ALL];
  assign clip_a_w  = (acc_evt_i.valid && acc_evt_i.a_sat) ||
                     (sw_status_wr ? (wd[CSF_B_CLIP_A] && clip_keep) : status[CSF_B_CLIP_A]);
  assign clip_b_w  = (acc_evt_i.valid && acc_evt_i.b_sat) ||
                     (sw_status_wr ? (wd[CSF_B_CLIP_B] && clip_keep) : status[CSF_B_CLIP_B]);

  // Half carry and general flags come from each ALU result.
  assign half_w = alu_req_i.valid ? hc_w : (sw_status_wr ? wd[CSF_B_HALF_C] : status[CSF_B_HALF_C]);
  assign gen_w  = alu_req_i.valid ? alu_req_i.nzvc :
                  (sw_status_wr ? wd[CSF_B_GEN_HI:0] : status[CSF_B_GEN_HI:0]);

  // Priority field is locked while nesting is disabled.
  assign prio_w = (sw_status_wr && !nest_dis) ? wd[CSF_B_PRIO_HI:CSF_B_PRIO_LO] :
                  status[CSF_B_PRIO_HI:CSF_B_PRIO_LO];

  // Unused positions 9 and 4 read as zero; summaries are ORs.
  assign next_status = {ovf_a_w, ovf_b_w, clip_a_w, clip_b_w,
                        ovf_a_w | ovf_b_w, clip_a_w | clip_b_w, 1'b0, half_w,
                        prio_w, 1'b0, gen_w};
  assign next_nest_dis = sw_ctrl_wr ? hwdata_i[CSF_B_NEST_DIS] : nest_dis;

  // Status word and control register.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status   <= CSF_STATUS_RST;
      nest_dis <= 1'b0;
    end else begin
      status   <= next_status;
      nest_dis <= next_nest_dis;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, enable and clear
  // ----------------------------------------------------------------
  logic [CSF_EV_W-1:0] irq_st;
  logic [CSF_EV_W-1:0] irq_en;
  logic [CSF_EV_W-1:0] ev_w;
  logic [CSF_EV_W-1:0] next_irq_st;
  logic [CSF_EV_W-1:0] next_irq_en;
  logic                next_irq;

  // Events: new clip on either accumulator, any overflow report.
  assign ev_w[CSF_B_EV_CLIPA] = acc_evt_i.valid && acc_evt_i.a_sat;
  assign ev_w[CSF_B_EV_CLIPB] = acc_evt_i.valid && acc_evt_i.b_sat;
  assign ev_w[CSF_B_EV_OVF]   = acc_evt_i.valid && (acc_evt_i.a_ovf || acc_evt_i.b_ovf);

  // Set wins over a clear arriving in the same cycle.
  assign next_irq_st = ev_w | (irq_st & ~(sw_clr_wr ? hwdata_i[CSF_EV_W-1:0] : {CSF_EV_W{1'b0}}));
  assign next_irq_en = sw_en_wr ? hwdata_i[CSF_EV_W-1:0] : irq_en;
  assign next_irq    = |(next_irq_st & next_irq_en);

  // Interrupt registers.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_st <= {CSF_EV_W{1'b0}};
      irq_en <= {CSF_EV_W{1'b0}};
      irq_o  <= 1'b0;
    end else begin
      irq_st <= next_irq_st;
      irq_en <= next_irq_en;
      irq_o  <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rd_w;
  logic [31:0] next_hrdata;

  // Read values come from next state so a write just before a read is seen.
  assign rd_w = addr_hit(acc_addr, CSF_OFF_STATUS)  ? {16'h0000, next_status} :
                addr_hit(acc_addr, CSF_OFF_CONTROL) ? {31'h0000_0000, next_nest_dis} :
                addr_hit(acc_addr, CSF_OFF_IRQ_ST)  ? {29'h0000_0000, next_irq_st} :
                addr_hit(acc_addr, CSF_OFF_IRQ_EN)  ? {29'h0000_0000, next_irq_en} :
                CSF_ZERO_WORD;
  assign next_hrdata = (acc_take && !hwrite_i) ? rd_w : CSF_ZERO_WORD;

  // Bus outputs; the slave never stalls and always answers OKAY.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o          <= CSF_ZERO_WORD;
      hreadyout_o       <= 1'b1;
      hresp_o           <= CSF_HRESP_OKAY;
      cpu_status_word_o <= CSF_STATUS_RST;
      nesting_disable_o <= 1'b0;
    end else begin
      hrdata_o          <= next_hrdata;
      hreadyout_o       <= 1'b1;
      hresp_o           <= CSF_HRESP_OKAY;
      cpu_status_word_o <= next_status;
      nesting_disable_o <= next_nest_dis;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] nib_chk;

  assign nib_chk = {1'b0, alu_req_i.op_a[3:0]} + {1'b0, alu_req_i.op_b[3:0]};

  chk_ovf_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
    acc_evt_i.valid |=> (status[CSF_B_OVF_A] == $past(acc_evt_i.a_ovf)) &&
                        (status[CSF_B_OVF_B] == $past(acc_evt_i.b_ovf)))
    else $error("Overflow flags do not follow the accumulator report.");

  chk_clip_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (acc_evt_i.valid && acc_evt_i.a_sat) |=> status[CSF_B_CLIP_A] [*1] ##1 (status[CSF_B_CLIP_A] || $past(sw_status_wr)))
    else $error("Clip flag A failed to set or hold.");

  chk_clip_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (status[CSF_B_CLIP_B] && !sw_status_wr) |=> status[CSF_B_CLIP_B])
    else $error("Clip flag B dropped without a software write.");

  chk_half_byte: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (alu_req_i.valid && alu_req_i.byte_mode && !alu_req_i.sub) |=> (status[CSF_B_HALF_C] == $past(nib_chk[4])))
    else $error("Half carry wrong for a byte addition.");

  chk_prio_locked: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (sw_status_wr && nest_dis) |=> $stable(status[CSF_B_PRIO_HI:CSF_B_PRIO_LO]))
    else $error("Priority field changed while locked.");

  chk_clip_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (sw_status_wr && !wd[CSF_B_CLIP_ALL] && !acc_evt_i.valid) |=>
      !status[CSF_B_CLIP_A] && !status[CSF_B_CLIP_B])
    else $error("Combined clip zero write did not clear both flags.");

  chk_combined_or: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cpu_status_word_o[CSF_B_OVF_ALL] == (cpu_status_word_o[CSF_B_OVF_A] | cpu_status_word_o[CSF_B_OVF_B])) &&
    (cpu_status_word_o[CSF_B_CLIP_ALL] == (cpu_status_word_o[CSF_B_CLIP_A] | cpu_status_word_o[CSF_B_CLIP_B])))
    else $error("Combined flags are not the OR of their parts.");

  chk_irq_level: assert property (@(posedge core_clk_i) disable iff (rst_i)
    irq_o == |(irq_st & irq_en))
    else $error("Interrupt output disagrees with enabled status.");

  chk_bus_ready: assert property (@(posedge core_clk_i) disable iff (rst_i)
    hreadyout_o && (hresp_o == CSF_HRESP_OKAY))
    else $error("Slave stalled or answered with an error.");

  cov_clip_clear: cover property (@(posedge core_clk_i) disable iff (rst_i)
    status[CSF_B_CLIP_A] ##1 (sw_status_wr && !wd[CSF_B_CLIP_ALL]));

  cov_prio_lock: cover property (@(posedge core_clk_i) disable iff (rst_i)
    sw_status_wr && nest_dis);

  cov_irq_raise: cover property (@(posedge core_clk_i) disable iff (rst_i)
    !irq_o ##1 irq_o);

endmodule

// *** logic/csf_pkg.sv ***
// Package with the register map, field layout and carrier types of the status flag block.
package csf_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CSF_OFF_STATUS  = 8'h00;
  localparam logic [7:0] CSF_OFF_CONTROL = 8'h04;
  localparam logic [7:0] CSF_OFF_IRQ_ST  = 8'h08;
  localparam logic [7:0] CSF_OFF_IRQ_CLR = 8'h0C;
  localparam logic [7:0] CSF_OFF_IRQ_EN  = 8'h10;

  // ----------------------------------------------------------------
  // Status word field positions
  // ----------------------------------------------------------------
  localparam int CSF_B_OVF_A   = 15;
  localparam int CSF_B_OVF_B   = 14;
  localparam int CSF_B_CLIP_A  = 13;
  localparam int CSF_B_CLIP_B  = 12;
  localparam int CSF_B_OVF_ALL = 11;
  localparam int CSF_B_CLIP_ALL = 10;
  localparam int CSF_B_HALF_C  = 8;
  localparam int CSF_B_PRIO_HI = 7;
  localparam int CSF_B_PRIO_LO = 5;
  localparam int CSF_B_GEN_HI  = 3;

  // Control and interrupt bit positions.
  localparam int CSF_B_NEST_DIS = 0;
  localparam int CSF_B_EV_CLIPA = 0;
  localparam int CSF_B_EV_CLIPB = 1;
  localparam int CSF_B_EV_OVF   = 2;
  localparam int CSF_EV_W       = 3;

  // ----------------------------------------------------------------
  // Reset values and bus constants
  // ----------------------------------------------------------------
  localparam logic [15:0] CSF_STATUS_RST = 16'h0000;
  localparam logic [31:0] CSF_ZERO_WORD  = 32'h0000_0000;
  localparam logic [1:0]  CSF_HTRANS_NSEQ = 2'h2;
  localparam logic [1:0]  CSF_HRESP_OKAY  = 2'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic a_ovf;
    logic b_ovf;
    logic a_sat;
    logic b_sat;
  } csf_acc_evt_t;

  typedef struct packed {
    logic        valid;
    logic        byte_mode;
    logic        sub;
    logic [15:0] op_a;
    logic [15:0] op_b;
    logic [3:0]  nzvc;
  } csf_alu_req_t;

endpackage

// *** logic/csf_half_carry.sv ***
// Half carry and borrow detector for byte and word arithmetic.
`timescale 1ns/1ps
module csf_half_carry (
  input  wire logic        byte_mode_i,
  input  wire logic        sub_i,
  input  wire logic [15:0] op_a_i,
  input  wire logic [15:0] op_b_i,
  output logic             half_carry_o
);
  import csf_pkg::*;

  // Subtraction adds the inverted operand plus one, so the carry out marks the borrow state.
  logic [15:0] addend;
  logic [4:0]  nib_sum;
  logic [8:0]  byte_sum;

  assign addend   = sub_i ? ~op_b_i : op_b_i;
  assign nib_sum  = {1'b0, op_a_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub_i};
  assign byte_sum = {1'b0, op_a_i[7:0]} + {1'b0, addend[7:0]} + {8'h00, sub_i};

  // Carry out of the fourth low bit for bytes, out of the eighth for words.
  assign half_carry_o = byte_mode_i ? nib_sum[4] : byte_sum[8];

endmodule

// *** tb/csf_datapath_model.sv ***
// Behavioural model of the arithmetic datapath that reports flag events to the status block.
`timescale 1ns/1ps
module csf_datapath_model (
  input  wire logic             core_clk_i,
  output csf_pkg::csf_acc_evt_t acc_evt_o,
  output csf_pkg::csf_alu_req_t alu_req_o
);
  import csf_pkg::*;

  // Both report lines start idle.
  initial begin
    acc_evt_o = '0;
    alu_req_o = '0;
  end

  // Sends one accumulator report as a one-cycle pulse, then shows the inverse so stale levels never match.
  task automatic send_acc(input logic [3:0] f);
    acc_evt_o <= {1'b1, f};
    @(posedge core_clk_i);
    acc_evt_o <= {1'b0, ~f};
    @(posedge core_clk_i);
  endtask

  // Sends one ALU result as a one-cycle pulse with the same idle handling.
  task automatic send_alu(input logic [37:0] r);
    alu_req_o <= {1'b1, r};
    @(posedge core_clk_i);
    alu_req_o <= {1'b0, ~r};
    @(posedge core_clk_i);
  endtask
endmodule

// *** tb/csf_status_flags_test.sv ***
// Self-checking testbench of the status flag block driven by a bus master and a datapath model.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module csf_status_flags_test;
  import csf_pkg::*;
  typedef struct packed {
    logic        src;
    logic [31:0] exp;
  } csf_note_t;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic          core_clk = 1'b0;
  logic          rst, hsel, hwrite, hready, nest_dis, irq, rd_pend, pchk;
  logic [31:0]   haddr, hwdata, hrdata;
  logic [1:0]    htrans, hresp;
  logic [2:0]    hsize;
  logic [15:0]   status_word;
  csf_acc_evt_t  acc_evt;
  csf_alu_req_t  alu_req;
  csf_note_t     notes[$];
  csf_note_t     note;
  int            errors = 0;
  int            cmp_count = 0;
  int            cycles = 0;
  int            seed = 76;
  logic          e_oa = 0, e_ob = 0, e_ca = 0, e_cb = 0, e_hc = 0, e_nest = 0;
  logic [2:0]    e_prio = 0, e_ist = 0, e_ien = 0;
  logic [3:0]    e_nzvc = 0;
  logic [7:0]    offs [6] = '{CSF_OFF_STATUS, CSF_OFF_CONTROL, CSF_OFF_IRQ_ST, CSF_OFF_IRQ_CLR, CSF_OFF_IRQ_EN, 8'h20};

  // The clock toggles every 20 ns, a half period of the 40 ns period.
  always #20 core_clk = ~core_clk;

  csf_status_flags dut_u (.core_clk_i(core_clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .acc_evt_i(acc_evt), .alu_req_i(alu_req),
    .cpu_status_word_o(status_word), .nesting_disable_o(nest_dis), .irq_o(irq));

  csf_datapath_model dp_u (.core_clk_i(core_clk), .acc_evt_o(acc_evt), .alu_req_o(alu_req));

  // ----------------------------------------------------------------
  // Expected model and drivers
  // ----------------------------------------------------------------
  function automatic logic [15:0] stw();
    return {e_oa, e_ob, e_ca, e_cb, e_oa | e_ob, e_ca | e_cb, 1'b0, e_hc, e_prio, 1'b0, e_nzvc};
  endfunction

  // Waits for the rising edge at which the slave shows hready high; only the timeout ends a hang.
  task automatic wait_rdy;
    do @(posedge core_clk); while (hready !== 1'b1);
  endtask

  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= CSF_HTRANS_NSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= w ? d : $random(seed);
    rd_pend <= !w;
    wait_rdy();
    rd_pend <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back({1'b0, e});
    bus(a, 1'b0, 32'h0);
  endtask

  // Notes the expected port values, then has them sampled one cycle later.
  task automatic chk_port;
    @(posedge core_clk);
    notes.push_back({1'b1, 11'h0, 1'b1, CSF_HRESP_OKAY, |(e_ist & e_ien), e_nest, stw()});
    pchk <= 1'b1;
    @(posedge core_clk);
    pchk <= 1'b0;
  endtask

  // Accumulator report, f is {a_ovf, b_ovf, a_sat, b_sat}.
  task automatic acc(input logic [3:0] f);
    dp_u.send_acc(f);
    e_oa = f[3];
    e_ob = f[2];
    e_ca |= f[1];
    e_cb |= f[0];
    e_ist |= {f[3] | f[2], f[0], f[1]};
  endtask

  // Random ALU result with its expected half carry, which for subtraction means no borrow.
  task automatic alu(input logic bm, input logic sb);
    logic [15:0] a, b, bx;
    logic [3:0]  f;
    logic [8:0]  s;
    a = $random(seed);
    b = $random(seed);
    f = $random(seed);
    bx = sb ? ~b : b;
    s = bm ? {4'h0, {1'b0, a[3:0]} + {1'b0, bx[3:0]} + sb} : {1'b0, a[7:0]} + {1'b0, bx[7:0]} + sb;
    e_hc = bm ? s[4] : s[8];
    e_nzvc = f;
    dp_u.send_alu({bm, sb, a, b, f});
  endtask

  // Status written as a whole word, never bit by bit.
  task automatic wr_st(input logic [15:0] d);
    bus(CSF_OFF_STATUS, 1'b1, {16'h0, d});
    e_oa = d[15];
    e_ob = d[14];
    e_hc = d[8];
    e_nzvc = d[3:0];
    e_ca = d[13] & d[10];
    e_cb = d[12] & d[10];
    if (!e_nest) e_prio = d[7:5];
  endtask

  task automatic end_of_test;
    if (notes.size() != 0) begin
      errors++;
      $display("mismatch note_queue exp 0 got %0d", notes.size());
    end
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Takes the oldest note whenever a read answer or a port sample appears.
  always @(posedge core_clk) begin
    if ((rd_pend && hready) || pchk) begin
      if (notes.size() == 0) begin
        errors++;
        $display("mismatch note_queue exp 1 got 0");
      end else begin
        note = notes.pop_front();
        if (note.src) `CHK("ports", note.exp, {11'h0, hready, hresp, irq, nest_dis, status_word})
        else `CHK("hrdata", note.exp, hrdata)
      end
    end
  end

  // Cuts a hung run short.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    rd_pend = 1'b0;
    pchk = 1'b0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    foreach (offs[i]) rd(offs[i], CSF_ZERO_WORD);
    chk_port();
    bus(CSF_OFF_IRQ_EN, 1'b1, 32'h0000_0007);
    e_ien = 3'h7;
    rd(CSF_OFF_IRQ_EN, 32'h0000_0007);
    acc(4'b1000);
    chk_port();
    rd(CSF_OFF_STATUS, {16'h0, stw()});
    acc(4'b0100);
    chk_port();
    acc(4'b0000);
    chk_port();
    acc(4'b0010);
    acc(4'b0000);
    chk_port();
    acc(4'b0001);
    chk_port();
    bus(CSF_OFF_IRQ_ST, 1'b1, CSF_ZERO_WORD);
    rd(CSF_OFF_IRQ_ST, {29'h0, e_ist});
    bus(CSF_OFF_IRQ_EN, 1'b1, CSF_ZERO_WORD);
    e_ien = 3'h0;
    chk_port();
    bus(CSF_OFF_IRQ_EN, 1'b1, 32'h0000_0007);
    e_ien = 3'h7;
    chk_port();
    bus(CSF_OFF_IRQ_CLR, 1'b1, 32'h0000_0007);
    e_ist = 3'h0;
    chk_port();
    rd(CSF_OFF_IRQ_CLR, CSF_ZERO_WORD);
    wr_st(16'h2400);
    chk_port();
    wr_st(16'h3000);
    chk_port();
    wr_st(16'h1400);
    rd(CSF_OFF_STATUS, {16'h0, stw()});
    wr_st(16'h00A0);
    bus(CSF_OFF_CONTROL, 1'b1, 32'h0000_0001);
    e_nest = 1'b1;
    wr_st(16'h0060);
    chk_port();
    rd(CSF_OFF_CONTROL, 32'h0000_0001);
    bus(CSF_OFF_CONTROL, 1'b1, CSF_ZERO_WORD);
    e_nest = 1'b0;
    wr_st(16'h0060);
    chk_port();
    for (int i = 0; i < 16; i++) begin
      alu(i[0], i[1]);
      chk_port();
    end
    // A report and a status write land on the same edge: the report wins for overflow and clip.
    fork
      bus(CSF_OFF_STATUS, 1'b1, 32'h0000_C000);
      begin
        @(posedge core_clk);
        dp_u.send_acc(4'b0010);
      end
    join
    {e_oa, e_ob, e_ca, e_cb, e_hc, e_prio, e_nzvc} = {4'b0010, 1'b0, 3'h0, 4'h0};
    e_ist |= 3'h1;
    chk_port();
    // A new clip event beats a clear of its interrupt bit on the same edge.
    fork
      bus(CSF_OFF_IRQ_CLR, 1'b1, 32'h0000_0001);
      begin
        @(posedge core_clk);
        dp_u.send_acc(4'b0010);
      end
    join
    rd(CSF_OFF_IRQ_ST, {29'h0, e_ist});
    chk_port();
    bus(8'h20, 1'b1, $random(seed));
    rd(8'h20, CSF_ZERO_WORD);
    repeat (2) @(posedge core_clk);
    end_of_test();
  end
endmodule
